// ==== include/acp_pkg.sv ====
// Package: register map, field positions and timing of the comparator pair
package acp_pkg;
  localparam int ACP_NCH = 2;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_EVENT_CONTROL_REG = 8'h08;
  localparam logic [7:0] OFS_INTEN = 8'h0C;
  localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_READY = 8'h18;
  localparam logic [7:0] OFS_DBG = 8'h1C;
  localparam logic [7:0] OFS_CH0 = 8'h20;
  localparam logic [7:0] OFS_CH1 = 8'h24;
  // Module control fields
  localparam int CTRL_SOFTWARE_RESET_BIT = 0;
  localparam int CTRL_ENABLE = 1;
  // Per-channel control fields
  localparam int CH_ENABLE = 0;
  localparam int CH_SINGLE = 1;
  localparam int CH_INTERRUPT_SELECT_LO = 3;
  localparam int CH_RUN_IN_STANDBY = 6;
  localparam int CH_NEGATIVE_INPUT_SELECT_LO = 8;
  localparam int CH_POSITIVE_INPUT_SELECT_LO = 12;
  localparam int CH_FILTER_LENGTH_LO = 24;
  localparam int CH_CFG_W = 27;
  // Event control fields: output event enable, start event enable
  localparam int EV_OUT_LO = 0;
  localparam int EV_IN_LO = 8;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Interrupt select codes
  localparam logic [1:0] ISEL_TOGGLE = 2'h0;
  localparam logic [1:0] ISEL_RISE = 2'h1;
  localparam logic [1:0] ISEL_FALL = 2'h2;
  localparam logic [1:0] ISEL_EOC = 2'h3;
  // Start-up delay
  localparam int STARTUP_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    ACP_OFF,
    ACP_WARM,
    ACP_RUN,
    ACP_IDLE
  } acp_state_t;
endpackage

// ==== rtl/acp_top.sv ====
// Control logic for a pair of analog comparators with AXI4-Lite registers
// Overview of operation
// [RULE_01] Result is high when positive input exceeds negative, else low.
// [RULE_02] Module enable bit turns the whole module on and off.
// [RULE_03] The external module-disable control must also allow operation.
// [RULE_04] Software reset returns all registers to reset and disables.
// [RULE_05] Event control accepts writes only while module disabled.
// [RULE_06] Channel configuration is locked while that channel is enabled.
// [RULE_07] Each channel enable bit works independently of the other.
// [RULE_08] Clearing module enable stops channels, keeps their enable bits.
// [RULE_09] Single-shot bit selects single-shot or continuous mode.
// [RULE_10] Result is not valid until the start-up delay has elapsed.
// [RULE_11] Interrupt select picks toggle, rising, falling or end of compare.
// [RULE_12] End-of-compare interrupt fires on completion regardless of output.
// [RULE_13] Output events follow the output state regardless of interrupts.
// [RULE_14] Debug halt stops after ongoing compare unless debug bit set.
// [RULE_15] Write guard blocks all writable registers but start and flags.
// [RULE_16] Write guard does not block debugger accesses.
// [RULE_17] Writes are carried into the comparator clock domain safely.
// [RULE_18] Module runs in idle and standby sleep; interrupts can wake.
// [RULE_19] In standby, events reach the event fabric without waking.
// [RULE_20] Result pin driven only when its system output enable is one.
// [RULE_21] Start bit begins one compare, clears ready; ready set at end.
// [RULE_22] Continuous mode compares always; start-up only for first compare.
// [RULE_23] Edge detect compares current and previous sample each cycle.
// [RULE_24] Flags clear by writing one; request while flag and enable set.
// [RULE_25] Software reset wins over other writes; enable reads cleared after.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
module acp_top
  import acp_pkg::*;
#(
  parameter int STARTUP_CYCLES = acp_pkg::STARTUP_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System controls
  input wire logic module_on,
  input wire logic write_guard,
  input wire logic debugger_access,
  input wire logic debug_halt,
  input wire logic standby,
  input wire logic [1:0] pin_output_enable,
  // Analog front end
  input wire logic [1:0] analog_above,
  output logic [1:0] comp_power,
  // Results
  output logic [1:0] result_pin,
  output logic [1:0] result_pin_oe,
  output logic [1:0] comp_event,
  output logic irq,
  output logic wake
);
  import acp_pkg::*;

  // Start-up counter is 16 bits wide
  generate
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65536)
    begin : g_bad_startup
      $error("STARTUP_CYCLES out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic wr_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  // Single clock: a held write acts at the next edge, no crossing needed
  assign do_write = aw_held && w_held && !s_axi_bvalid; // [RULE_17]
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= RST_ZERO;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic mod_en;
  logic software_reset_bit;
  logic [15:0] ev_ctrl;
  logic [1:0] int_en;
  logic [1:0] int_flag;
  logic [1:0] ready;
  logic [1:0] state;
  logic dbg_run;
  logic [CH_CFG_W-1:0] ch_cfg [ACP_NCH];
  logic [1:0] ch_en;
  logic [1:0] set_flag;
  logic [1:0] done;
  logic [1:0] sw_start;
  logic guarded;
  logic known;

  // Guard applies except to start and flag registers
  assign guarded = write_guard && !debugger_access &&
    aw_addr != OFS_START && aw_addr != OFS_INTERRUPT_FLAGS; // [RULE_15] [RULE_16]
  always_comb
  begin
    case (aw_addr)
      OFS_CTRL, OFS_START, OFS_EVENT_CONTROL_REG, OFS_INTEN, OFS_INTERRUPT_FLAGS,
      OFS_DBG, OFS_CH0, OFS_CH1: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign wr_ok = known && !guarded;

  function automatic logic wr_hit(input logic [7:0] ofs);
    return do_write && wr_ok && aw_addr == ofs && w_strb[0];
  endfunction

  always_comb
  begin
    sw_start = 2'b00;
    if (wr_hit(OFS_START))
    begin
      sw_start = w_data[1:0];
    end
  end

  // Reset pulse lasts one cycle; all registers return to zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      software_reset_bit <= 1'b0;
      mod_en <= 1'b0;
    end
    else if (software_reset_bit)
    begin
      software_reset_bit <= 1'b0;
      mod_en <= 1'b0; // [RULE_25]
    end
    else if (wr_hit(OFS_CTRL))
    begin
      software_reset_bit <= w_data[CTRL_SOFTWARE_RESET_BIT]; // [RULE_04]
      mod_en <= w_data[CTRL_ENABLE] && !w_data[CTRL_SOFTWARE_RESET_BIT]; // [RULE_02]
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ev_ctrl <= 16'h0000;
      int_en <= 2'b00;
      dbg_run <= 1'b0;
    end
    else if (software_reset_bit)
    begin
      ev_ctrl <= 16'h0000; // [RULE_04]
      int_en <= 2'b00;
      dbg_run <= 1'b0;
    end
    else
    begin
      if (wr_hit(OFS_EVENT_CONTROL_REG) && !mod_en)
      begin
        ev_ctrl <= w_data[15:0]; // [RULE_05]
      end
      if (wr_hit(OFS_INTEN))
      begin
        int_en <= w_data[1:0];
      end
      if (wr_hit(OFS_DBG))
      begin
        dbg_run <= w_data[0];
      end
    end
  end

  generate
    for (genvar c = 0; c < ACP_NCH; c++)
    begin : g_cfg
      logic [7:0] ofs;
      assign ofs = c == 0 ? OFS_CH0 : OFS_CH1;
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          ch_cfg[c] <= '0;
        end
        else if (software_reset_bit)
        begin
          ch_cfg[c] <= '0;
        end
        else if (wr_hit(ofs))
        begin
          ch_cfg[c][CH_ENABLE] <= w_data[CH_ENABLE]; // [RULE_07]
          if (!ch_cfg[c][CH_ENABLE])
          begin
            ch_cfg[c][CH_CFG_W-1:1] <= w_data[CH_CFG_W-1:1]; // [RULE_06]
          end
        end
      end
      // Module enable gates channels without clearing their bits
      assign ch_en[c] = ch_cfg[c][CH_ENABLE] && mod_en && module_on; // [RULE_03] [RULE_08]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Comparator channels
  // ----------------------------------------------------------------
  logic [1:0] prev;
  logic [1:0] run_ok;

  generate
    for (genvar c = 0; c < ACP_NCH; c++)
    begin : g_ch
      acp_state_t st;
      logic [15:0] cnt;
      logic single;
      logic [1:0] isel;
      logic trig;
      logic cmp;
      logic edge_hit;
      assign single = ch_cfg[c][CH_SINGLE];
      assign isel = ch_cfg[c][CH_INTERRUPT_SELECT_LO+:2];
      assign trig = sw_start[c] || ev_ctrl[EV_IN_LO+c];
      // Debug halt lets an ongoing compare finish
      assign run_ok[c] = !(debug_halt && !dbg_run) &&
        (!standby || ch_cfg[c][CH_RUN_IN_STANDBY]); // [RULE_14] [RULE_18]
      assign cmp = analog_above[c]; // [RULE_01]
      assign comp_power[c] = st == ACP_WARM || st == ACP_RUN;

      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          st <= ACP_OFF;
          cnt <= 16'h0000;
          done[c] <= 1'b0;
        end
        else
        begin
          done[c] <= 1'b0;
          case (st)
            ACP_OFF:
            begin
              if (ch_en[c] && run_ok[c])
              begin
                st <= single ? ACP_IDLE : ACP_WARM; // [RULE_09]
                cnt <= 16'h0000;
              end
            end
            ACP_IDLE:
            begin
              if (!ch_en[c])
              begin
                st <= ACP_OFF;
              end
              else if (trig && run_ok[c])
              begin
                st <= ACP_WARM; // [RULE_21]
                cnt <= 16'h0000;
              end
            end
            ACP_WARM:
            begin
              if (!ch_en[c])
              begin
                st <= ACP_OFF;
              end
              else if (cnt == 16'(STARTUP_CYCLES - 1))
              begin
                done[c] <= 1'b1; // [RULE_10]
                st <= single ? ACP_IDLE : ACP_RUN;
              end
              else
              begin
                cnt <= cnt + 16'h0001;
              end
            end
            ACP_RUN:
            begin
              if (!ch_en[c] || !run_ok[c])
              begin
                st <= ACP_OFF;
              end
              else
              begin
                done[c] <= 1'b1; // [RULE_22]
              end
            end
            default: st <= ACP_OFF;
          endcase
        end
      end

      always_comb
      begin
        case (isel)
          ISEL_RISE: edge_hit = !prev[c] && cmp;
          ISEL_FALL: edge_hit = prev[c] && !cmp;
          ISEL_EOC: edge_hit = 1'b1; // [RULE_12]
          default: edge_hit = prev[c] != cmp;
        endcase
      end
      assign set_flag[c] = done[c] && edge_hit; // [RULE_11] [RULE_23]
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= 2'b00;
      prev <= 2'b00;
      ready <= 2'b00;
      comp_event <= 2'b00;
    end
    else if (software_reset_bit)
    begin
      state <= 2'b00; // [RULE_04]
      prev <= 2'b00;
      ready <= 2'b00;
      comp_event <= 2'b00;
    end
    else
    begin
      for (int c = 0; c < ACP_NCH; c++)
      begin
        comp_event[c] <= 1'b0;
        if (done[c])
        begin
          state[c] <= analog_above[c];
          prev[c] <= analog_above[c]; // [RULE_23]
          ready[c] <= 1'b1; // [RULE_21]
          // Event regardless of interrupt enable
          comp_event[c] <= ev_ctrl[EV_OUT_LO+c] && analog_above[c]; // [RULE_13] [RULE_19]
        end
        else if (sw_start[c] || !ch_en[c])
        begin
          ready[c] <= 1'b0; // [RULE_21]
        end
      end
    end
  end

  // Hardware set wins over write-one clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_flag <= 2'b00;
    end
    else if (software_reset_bit)
    begin
      int_flag <= 2'b00;
    end
    else
    begin
      int_flag <= (int_flag & ~(wr_hit(OFS_INTERRUPT_FLAGS) ? w_data[1:0] : 2'b00))
        | set_flag; // [RULE_24]
    end
  end
  assign irq = |(int_flag & int_en); // [RULE_24]
  assign wake = irq && standby; // [RULE_18]

  // Pins only driven when system output enable set
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      result_pin <= 2'b00;
      result_pin_oe <= 2'b00;
    end
    else
    begin
      result_pin <= state;
      result_pin_oe <= pin_output_enable; // [RULE_20]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_ZERO;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        OFS_CTRL: s_axi_rdata <= {30'h0, mod_en, software_reset_bit};
        OFS_EVENT_CONTROL_REG: s_axi_rdata <= {16'h0000, ev_ctrl};
        OFS_INTEN: s_axi_rdata <= {30'h0, int_en};
        OFS_INTERRUPT_FLAGS: s_axi_rdata <= {30'h0, int_flag};
        OFS_STATE: s_axi_rdata <= {30'h0, state};
        OFS_READY: s_axi_rdata <= {30'h0, ready};
        OFS_DBG: s_axi_rdata <= {31'h0, dbg_run};
        OFS_CH0: s_axi_rdata <= {5'h00, ch_cfg[0]};
        OFS_CH1: s_axi_rdata <= {5'h00, ch_cfg[1]};
        default: s_axi_rdata <= RST_ZERO;
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_evlock;
    @(posedge clk) disable iff (sys_rst)
      mod_en && !software_reset_bit |=> $stable(ev_ctrl) || !$past(mod_en);
  endproperty
  a_evlock: assert property (p_evlock) else $error("event ctrl changed"); // [RULE_05]

  property p_software_reset_bit;
    @(posedge clk) disable iff (sys_rst)
      software_reset_bit |=> !mod_en && int_flag == 2'b00 && ev_ctrl == 16'h0000 &&
        ready == 2'b00 && state == 2'b00;
  endproperty
  a_software_reset_bit: assert property (p_software_reset_bit) else $error("soft reset failed"); // [RULE_04]

  property p_lock;
    @(posedge clk) disable iff (sys_rst)
      ch_cfg[0][CH_ENABLE] && !software_reset_bit |=>
        $past(ch_cfg[0][CH_CFG_W-1:1]) == ch_cfg[0][CH_CFG_W-1:1];
  endproperty
  a_lock: assert property (p_lock) else $error("config changed"); // [RULE_06]

  property p_gate;
    @(posedge clk) disable iff (sys_rst)
      !mod_en |=> comp_power == 2'b00;
  endproperty
  a_gate: assert property (p_gate) else $error("channel on"); // [RULE_08]

  property p_irq;
    @(posedge clk) disable iff (sys_rst)
      do_write && wr_ok && aw_addr == OFS_INTERRUPT_FLAGS && w_strb[0] &&
        w_data[0] && !set_flag[0] && !software_reset_bit |=> !int_flag[0];
  endproperty
  a_irq: assert property (p_irq) else $error("flag stuck"); // [RULE_24]

  property p_flagset;
    @(posedge clk) disable iff (sys_rst)
      set_flag[0] && !software_reset_bit |=> int_flag[0];
  endproperty
  a_flagset: assert property (p_flagset) else $error("flag lost"); // [RULE_24]

  property p_ready;
    @(posedge clk) disable iff (sys_rst)
      done[0] && !software_reset_bit |=> ready[0] && state[0] == $past(analog_above[0]);
  endproperty
  a_ready: assert property (p_ready) else $error("ready not set"); // [RULE_21]

  property p_oe;
    @(posedge clk) disable iff (sys_rst)
      ##1 result_pin_oe == $past(pin_output_enable);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong"); // [RULE_20]

  c_eoc: cover property (@(posedge clk) disable iff (sys_rst) set_flag[0]);
  c_ev: cover property (@(posedge clk) disable iff (sys_rst) comp_event[0]);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) irq);
endmodule

// ==== sim/tb_top.sv ====
// Register-level testbench for the comparator pair control block
`timescale 1ns/1ns
module tb_top;
  import acp_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int SC = 3;
  logic clk, sys_rst;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic module_on, write_guard, debugger_access, debug_halt, standby;
  logic [1:0] pin_oe, above, comp_power, result_pin, result_pin_oe;
  logic [1:0] comp_event;
  logic irq, wake;
  int miscompares = 0;
  int n_tests = 0;
  int ev0_cnt = 0;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [1:0] isel;

  acp_top #(.STARTUP_CYCLES(SC)) i_acp_top (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_on(module_on), .write_guard(write_guard),
    .debugger_access(debugger_access), .debug_halt(debug_halt),
    .standby(standby), .pin_output_enable(pin_oe),
    .analog_above(above), .comp_power(comp_power),
    .result_pin(result_pin), .result_pin_oe(result_pin_oe),
    .comp_event(comp_event), .irq(irq), .wake(wake)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (comp_event[0] === 1'b1)
      ev0_cnt++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Address and data may be taken at different edges
    while (!(ad && wd) && n < 100)
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bvalid !== 1'b1 && n < 100);
    // Ready lines stay high between transfers
    r = bresp;
    if (n >= 100)
      check("write timeout", 0, 1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    if (n >= 100)
      check("read timeout", 0, 1);
  endtask

  task automatic w_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(nm, d, exp);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    module_on = 1'b1;
    {write_guard, debugger_access, debug_halt, standby} = '0;
    pin_oe = 2'b00;
    above = 2'b00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk("ctrl reset", OFS_CTRL, RST_ZERO);
    rd_chk("event_control_reg reset", OFS_EVENT_CONTROL_REG, RST_ZERO);
    rd_chk("ch0 reset", OFS_CH0, RST_ZERO);
    rd_chk("ready reset", OFS_READY, RST_ZERO);
    wr(8'h40, 32'h0000_0001, rs);
    check("unmapped bresp", rs, 2'h2);
    rd_chk("unmapped read", 8'h40, RST_ZERO);
    // Guarded writes fail unless they come from the debugger or go to the start or flag registers
    write_guard <= 1'b1;
    wr(OFS_CH0, 32'h0000_0002, rs);
    check("guarded bresp", rs, 2'h2);
    rd_chk("guarded ch0", OFS_CH0, RST_ZERO);
    wr(OFS_INTERRUPT_FLAGS, 32'h0000_0000, rs);
    check("flag bresp", rs, 2'h0);
    debugger_access <= 1'b1;
    wr(OFS_CH0, 32'h0000_0002, rs);
    check("debugger bresp", rs, 2'h0);
    rd_chk("debugger ch0", OFS_CH0, 32'h0000_0002);
    write_guard <= 1'b0;
    debugger_access <= 1'b0;
    w_ok(OFS_EVENT_CONTROL_REG, 32'h0000_0001);
    rd_chk("event_control_reg off", OFS_EVENT_CONTROL_REG, 32'h0000_0001);
    w_ok(OFS_CTRL, 32'h0000_0002);
    w_ok(OFS_EVENT_CONTROL_REG, 32'h0000_0003);
    rd_chk("event_control_reg on", OFS_EVENT_CONTROL_REG, 32'h0000_0001);
    // Channel 0: single shot, end-of-compare interrupt
    w_ok(OFS_INTEN, 32'h0000_0003);
    w_ok(OFS_CH0, 32'h0000_001B);
    w_ok(OFS_CH0, 32'h0000_1003);
    rd_chk("ch0 locked", OFS_CH0, 32'h0000_001B);
    above <= 2'b01;
    repeat (20) @(posedge clk);
    ev0_cnt = 0;
    w_ok(OFS_START, 32'h0000_0001);
    rd(OFS_READY, rv);
    check("startup ready", rv[0], 1'b0);
    for (int i = 0; i < 40 && rv[0] !== 1'b1; i++)
      rd(OFS_READY, rv);
    check("ready set", rv[0], 1'b1);
    rd(OFS_STATE, rv);
    check("state high", rv[0], 1'b1);
    check("result pin", result_pin[0], 1'b1);
    rd(OFS_INTERRUPT_FLAGS, rv);
    check("eoc flag", rv[0], 1'b1);
    check("irq", irq, 1'b1);
    check("event once", ev0_cnt, 1);
    standby <= 1'b1;
    @(posedge clk);
    check("wake", wake, 1'b1);
    standby <= 1'b0;
    w_ok(OFS_INTERRUPT_FLAGS, 32'h0000_0001);
    rd_chk("flag w1c", OFS_INTERRUPT_FLAGS, RST_ZERO);
    check("irq low", irq, 1'b0);
    above <= 2'b00;
    w_ok(OFS_START, 32'h0000_0001);
    rd(OFS_READY, rv);
    check("ready cleared", rv[0], 1'b0);
    repeat (SC + 10) @(posedge clk);
    rd(OFS_STATE, rv);
    check("state low", rv[0], 1'b0);
    rd(OFS_INTERRUPT_FLAGS, rv);
    check("eoc low out", rv[0], 1'b1);
    // Debug halt blocks a new compare unless run-in-debug is set
    debug_halt <= 1'b1;
    w_ok(OFS_START, 32'h0000_0001);
    repeat (SC + 10) @(posedge clk);
    rd(OFS_READY, rv);
    check("halt ready", rv[0], 1'b0);
    w_ok(OFS_DBG, 32'h0000_0001);
    w_ok(OFS_START, 32'h0000_0001);
    repeat (SC + 10) @(posedge clk);
    rd(OFS_READY, rv);
    check("debug run ready", rv[0], 1'b1);
    debug_halt <= 1'b0;
    // Channel 1 continuous, each edge code
    for (int k = 0; k < 3; k++)
    begin
      isel = 2'(k);
      w_ok(OFS_CH1, RST_ZERO);
      w_ok(OFS_CH1, {27'h0, isel, 3'b001});
      repeat (SC + 10) @(posedge clk);
      w_ok(OFS_INTERRUPT_FLAGS, 32'h0000_0003);
      above[1] <= 1'b1;
      repeat (6) @(posedge clk);
      rd(OFS_STATE, rv);
      check("cont state", rv[1], 1'b1);
      check("ch1 power", comp_power[1], 1'b1);
      rd(OFS_INTERRUPT_FLAGS, rv);
      check("rise flag", rv[1], isel != ISEL_FALL);
      w_ok(OFS_INTERRUPT_FLAGS, 32'h0000_0003);
      above[1] <= 1'b0;
      repeat (6) @(posedge clk);
      rd(OFS_INTERRUPT_FLAGS, rv);
      check("fall flag", rv[1], isel != ISEL_RISE);
    end
    w_ok(OFS_CTRL, RST_ZERO);
    rd(OFS_CH1, rv);
    check("ch enable kept", rv[CH_ENABLE], 1'b1);
    check("ch power off", comp_power, 2'b00);
    pin_oe <= 2'b10;
    repeat (3) @(posedge clk);
    check("pin oe", result_pin_oe, 2'b10);
    // Module blocked by external disable
    module_on <= 1'b0;
    w_ok(OFS_CTRL, 32'h0000_0002);
    w_ok(OFS_START, 32'h0000_0001);
    repeat (SC + 20) @(posedge clk);
    rd(OFS_READY, rv);
    check("blocked ready", rv[0], 1'b0);
    module_on <= 1'b1;
    w_ok(OFS_CTRL, 32'h0000_0003);
    repeat (2) @(posedge clk);
    rd_chk("software_reset_bit ctrl", OFS_CTRL, RST_ZERO);
    rd_chk("software_reset_bit ch0", OFS_CH0, RST_ZERO);
    rd_chk("software_reset_bit event_control_reg", OFS_EVENT_CONTROL_REG, RST_ZERO);
    rd_chk("software_reset_bit inten", OFS_INTEN, RST_ZERO);
    end_of_test();
  end
endmodule
